//--- include/mac_pkg.sv
// constants, opcodes and operation codes of the multiply-accumulate datapath
`default_nettype none
package mac_pkg;
    localparam int DATA_W     = 32;
    localparam int ACC_W      = 64;
    localparam int ACC_COUNT  = 4;
    localparam int SEL_W      = 2;
    localparam int GREG_W     = 5;

    // instruction field positions
    localparam int MAJOR_MSB  = 31;
    localparam int MAJOR_LSB  = 26;
    localparam int FIELD1_MSB = 25;
    localparam int FIELD1_LSB = 21;
    localparam int FIELD2_MSB = 20;
    localparam int FIELD2_LSB = 16;
    localparam int SEL_MSB    = 15;
    localparam int SEL_LSB    = 14;
    localparam int EXT_MSB    = 13;
    localparam int EXT_LSB    = 6;
    localparam int MINOR_MSB  = 5;
    localparam int MINOR_LSB  = 0;

    localparam logic [5:0] MAJOR_GROUP     = 6'h00;
    localparam logic [5:0] MINOR_GROUP     = 6'h3c;
    localparam logic [4:0] FIELD1_ZERO     = 5'h00;
    localparam logic [7:0] EXT_READ_UPPER  = 8'h01;
    localparam logic [7:0] EXT_LEFT_PSAT   = 8'h69;
    localparam logic [7:0] EXT_LEFT_SSAT   = 8'he9;
    localparam logic [7:0] EXT_RIGHT_PSAT  = 8'h29;
    localparam logic [7:0] EXT_RIGHT_SSAT  = 8'ha9;
    localparam logic [7:0] EXT_UNSIGNED_MAC = 8'h6a;

    // register map and control register layout
    localparam int         ADDR_W          = 8;
    localparam logic [7:0] CTRL_OFFSET     = 8'h00;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
    localparam int         OVF_LSB         = 16;
    localparam int         OVF_W           = 4;

    localparam logic [15:0] Q15_NEG_ONE    = 16'h8000;
    localparam logic [31:0] Q31_MAX        = 32'h7fff_ffff;
    localparam logic [31:0] Q31_MIN        = 32'h8000_0000;

    typedef enum logic [6:0] {
        OP_NONE    = 7'b000_0001,
        OP_UMAC    = 7'b000_0010,
        OP_RDUP    = 7'b000_0100,
        OP_FRAC_LP = 7'b000_1000,
        OP_FRAC_LS = 7'b001_0000,
        OP_FRAC_RP = 7'b010_0000,
        OP_FRAC_RS = 7'b100_0000
    } op_e;
endpackage
`default_nettype wire

//--- include/acc_mem_if.sv
// accumulator storage access between the datapath and its store
`default_nettype none
interface acc_mem_if;
    logic [1:0]  rd_idx;
    logic [63:0] rd_data;
    logic        wr_en;
    logic [1:0]  wr_idx;
    logic [63:0] wr_data;
    modport core  (output rd_idx, output wr_en, output wr_idx, output wr_data, input rd_data);
    modport store (input rd_idx, input wr_en, input wr_idx, input wr_data, output rd_data);
endinterface
`default_nettype wire

//--- verilog/acc_store.sv
// four 64-bit accumulators with registered, write-forwarding read
`default_nettype none
module acc_store
    import mac_pkg::*;
(
    input  wire logic clock,
    input  wire logic sys_rst,
    acc_mem_if.store  mem
);
    logic [ACC_W-1:0] acc_q [ACC_COUNT];
    logic             fwd;

    // a write to the entry being read is passed on so back-to-back ops chain
    assign fwd = mem.wr_en && (mem.wr_idx == mem.rd_idx);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 0; i < ACC_COUNT; i++) begin
                acc_q[i] <= '0;
            end
            mem.rd_data <= '0;
        end else begin
            if (mem.wr_en) begin
                acc_q[mem.wr_idx] <= mem.wr_data;
            end
            mem.rd_data <= fwd ? mem.wr_data : acc_q[mem.rd_idx];
        end
    end
endmodule
`default_nettype wire

//--- verilog/mac_datapath.sv
// multiply-accumulate execution unit with four accumulators and a control register
`default_nettype none
module mac_datapath
    import mac_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               sys_rst,
    input  wire logic               instr_valid,
    input  wire logic [DATA_W-1:0]  instr_word,
    input  wire logic [DATA_W-1:0]  operand_a_value,
    input  wire logic [DATA_W-1:0]  operand_b_value,
    input  wire logic               dsp_enable,
    input  wire logic [ADDR_W-1:0]  reg_addr,
    input  wire logic [DATA_W-1:0]  reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [DATA_W-1:0]  reg_rdata,
    output logic                    general_register_wr,
    output logic      [GREG_W-1:0]  general_register_idx,
    output logic      [DATA_W-1:0]  general_register_data,
    output logic                    reserved_instr_exc,
    output logic                    dsp_disabled_exc
);
    function automatic logic is_frac(input op_e op);
        is_frac = (op == OP_FRAC_LP) || (op == OP_FRAC_LS) ||
                  (op == OP_FRAC_RP) || (op == OP_FRAC_RS);
    endfunction

    function automatic logic is_sum_sat(input op_e op);
        is_sum_sat = (op == OP_FRAC_LS) || (op == OP_FRAC_RS);
    endfunction

    // returns {saturated, q31}
    function automatic logic [32:0] frac_product(input logic [15:0] x, input logic [15:0] y);
        logic signed [31:0] p;
        p = $signed(x) * $signed(y);
        if ((x == Q15_NEG_ONE) && (y == Q15_NEG_ONE)) begin
            frac_product = {1'b1, Q31_MAX};
        end else begin
            frac_product = {1'b0, p[30:0], 1'b0};
        end
    endfunction

    acc_mem_if mem ();

    acc_store u_store (
        .clock   (clock),
        .sys_rst (sys_rst),
        .mem     (mem)
    );

    // decode
    logic            grp_hit;
    logic [7:0]      ext_code;
    logic            dec_umac;
    logic            dec_rdup;
    logic            dec_lp;
    logic            dec_ls;
    logic            dec_rp;
    logic            dec_rs;
    logic            dec_frac;
    logic            dsp_block;
    logic            dec_reserved;
    op_e             op_d;

    assign grp_hit  = (instr_word[MAJOR_MSB:MAJOR_LSB] == MAJOR_GROUP) &&
                      (instr_word[MINOR_MSB:MINOR_LSB] == MINOR_GROUP);
    assign ext_code = instr_word[EXT_MSB:EXT_LSB];
    assign dec_umac = grp_hit && (ext_code == EXT_UNSIGNED_MAC);
    assign dec_rdup = grp_hit && (ext_code == EXT_READ_UPPER) &&
                      (instr_word[FIELD1_MSB:FIELD1_LSB] == FIELD1_ZERO);
    assign dec_lp   = grp_hit && (ext_code == EXT_LEFT_PSAT);
    assign dec_ls   = grp_hit && (ext_code == EXT_LEFT_SSAT);
    assign dec_rp   = grp_hit && (ext_code == EXT_RIGHT_PSAT);
    assign dec_rs   = grp_hit && (ext_code == EXT_RIGHT_SSAT);
    assign dec_frac = dec_lp || dec_ls || dec_rp || dec_rs;
    // only the decode outcome and the enable may fault, never operand data
    assign dsp_block    = instr_valid && dec_frac && !dsp_enable;
    assign dec_reserved = instr_valid && !(dec_umac || dec_rdup || dec_frac);

    assign op_d = (!instr_valid || dsp_block) ? OP_NONE :
                  dec_umac ? OP_UMAC :
                  dec_rdup ? OP_RDUP :
                  dec_lp   ? OP_FRAC_LP :
                  dec_ls   ? OP_FRAC_LS :
                  dec_rp   ? OP_FRAC_RP :
                  dec_rs   ? OP_FRAC_RS : OP_NONE;

    // accumulator read is issued alongside decode
    assign mem.rd_idx = instr_word[SEL_MSB:SEL_LSB];

    // execute stage registers
    op_e              s1_op_q;
    logic [SEL_W-1:0] s1_sel_q;
    logic [DATA_W-1:0] s1_a_q;
    logic [DATA_W-1:0] s1_b_q;
    logic [GREG_W-1:0] s1_dest_q;
    logic             s1_res_q;
    logic             s1_dsp_q;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s1_op_q   <= OP_NONE;
            s1_sel_q  <= '0;
            s1_a_q    <= '0;
            s1_b_q    <= '0;
            s1_dest_q <= '0;
            s1_res_q  <= 1'b0;
            s1_dsp_q  <= 1'b0;
        end else begin
            s1_op_q   <= op_d;
            s1_sel_q  <= instr_word[SEL_MSB:SEL_LSB];
            s1_a_q    <= operand_a_value;
            s1_b_q    <= operand_b_value;
            s1_dest_q <= instr_word[FIELD2_MSB:FIELD2_LSB];
            s1_res_q  <= dec_reserved;
            s1_dsp_q  <= dsp_block;
        end
    end

    // execute
    logic [ACC_W-1:0]  acc_cur;
    logic [ACC_W-1:0]  umac_prod;
    logic              left_sel;
    logic [15:0]       half_a;
    logic [15:0]       half_b;
    logic [32:0]       fp;
    logic              prod_sat;
    logic [31:0]       q31;
    logic [ACC_W-1:0]  frac_ext;
    logic [ACC_W-1:0]  frac_sum;
    logic              sum_ovf;
    logic              clamp_hit;
    logic [ACC_W-1:0]  clamp_val;
    logic [ACC_W-1:0]  frac_res;
    logic              frac_flag;
    logic [OVF_W-1:0]  ovf_bits;

    assign acc_cur   = mem.rd_data;
    assign umac_prod = 64'(s1_a_q) * 64'(s1_b_q);
    assign left_sel  = (s1_op_q == OP_FRAC_LP) || (s1_op_q == OP_FRAC_LS);
    assign half_a    = left_sel ? s1_a_q[31:16] : s1_a_q[15:0];
    assign half_b    = left_sel ? s1_b_q[31:16] : s1_b_q[15:0];
    assign fp        = frac_product(half_a, half_b);
    assign prod_sat  = fp[32];
    assign q31       = fp[31:0];
    assign frac_ext  = {{32{q31[31]}}, q31};
    assign frac_sum  = acc_cur + frac_ext;
    assign sum_ovf   = frac_sum[32] != frac_sum[31];
    // clamp direction follows the sign of the exact 64-bit sum
    assign clamp_val = frac_sum[63] ? {{32{1'b1}}, Q31_MIN} : {32'h0000_0000, Q31_MAX};
    assign clamp_hit = is_sum_sat(s1_op_q) && sum_ovf;
    assign frac_res  = clamp_hit ? clamp_val : frac_sum;
    assign frac_flag = is_frac(s1_op_q) && (prod_sat || clamp_hit);
    assign ovf_bits  = frac_flag ? OVF_W'(4'h1 << s1_sel_q) : '0;

    assign mem.wr_en   = (s1_op_q == OP_UMAC) || is_frac(s1_op_q);
    assign mem.wr_idx  = s1_sel_q;
    assign mem.wr_data = (s1_op_q == OP_UMAC) ? (acc_cur + umac_prod) : frac_res;

    // control register and read port
    logic [DATA_W-1:0] ctrl_q;
    logic [DATA_W-1:0] ctrl_d;
    logic              ctrl_wr;
    logic              ctrl_rd;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;

    assign ctrl_wr = reg_wr && (reg_addr == CTRL_OFFSET);
    assign ctrl_rd = reg_rd && (reg_addr == CTRL_OFFSET);
    // a flag raised in the cycle of a software write survives it
    assign ctrl_d  = (ctrl_wr ? reg_wdata : ctrl_q) |
                     {{(DATA_W-OVF_LSB-OVF_W){1'b0}}, ovf_bits, {OVF_LSB{1'b0}}};
    assign rdata_d = ctrl_rd ? ctrl_q : '0;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_q  <= CTRL_RESET;
            rdata_q <= '0;
        end else begin
            ctrl_q  <= ctrl_d;
            rdata_q <= rdata_d;
        end
    end

    // general register result and exceptions
    logic              gwr_q;
    logic [GREG_W-1:0] gidx_q;
    logic [DATA_W-1:0] gdata_q;
    logic              res_exc_q;
    logic              dsp_exc_q;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            gwr_q     <= 1'b0;
            gidx_q    <= '0;
            gdata_q   <= '0;
            res_exc_q <= 1'b0;
            dsp_exc_q <= 1'b0;
        end else begin
            gwr_q     <= s1_op_q == OP_RDUP;
            gidx_q    <= s1_dest_q;
            gdata_q   <= (s1_op_q == OP_RDUP) ? acc_cur[63:32] : '0;
            res_exc_q <= s1_res_q;
            dsp_exc_q <= s1_dsp_q;
        end
    end

    assign reg_rdata             = rdata_q;
    assign general_register_wr   = gwr_q;
    assign general_register_idx  = gidx_q;
    assign general_register_data = gdata_q;
    assign reserved_instr_exc    = res_exc_q;
    assign dsp_disabled_exc      = dsp_exc_q;

    // checks
    logic signed [31:0] right_prod;
    assign right_prod = $signed(s1_a_q[15:0]) * $signed(s1_b_q[15:0]);

    a_umac_accum: assert property (@(posedge clock) disable iff (sys_rst)
        instr_valid && (op_d == OP_UMAC) |=> mem.wr_en &&
        (mem.wr_idx == $past(instr_word[SEL_MSB:SEL_LSB])) &&
        (mem.wr_data == mem.rd_data + 64'($past(operand_a_value)) * 64'($past(operand_b_value))))
        else $error("unsigned accumulate result wrong");

    a_umac_quiet: assert property (@(posedge clock) disable iff (sys_rst)
        instr_valid && (op_d == OP_UMAC) |-> ##2 !gwr_q && !res_exc_q && !dsp_exc_q)
        else $error("unsigned accumulate wrote a register or faulted");

    a_upper_copy: assert property (@(posedge clock) disable iff (sys_rst)
        (s1_op_q == OP_RDUP) |=> gwr_q && (gdata_q == $past(mem.rd_data[63:32])) &&
        (gidx_q == $past(s1_dest_q)))
        else $error("upper word move wrong");

    a_left_sat_flag: assert property (@(posedge clock) disable iff (sys_rst)
        left_sel && (s1_a_q[31:16] == Q15_NEG_ONE) && (s1_b_q[31:16] == Q15_NEG_ONE)
        |=> ctrl_q[OVF_LSB + 32'($past(s1_sel_q))])
        else $error("left saturation did not set overflow bit");

    a_right_psat: assert property (@(posedge clock) disable iff (sys_rst)
        (s1_op_q == OP_FRAC_RP) && !((s1_a_q[15:0] == Q15_NEG_ONE) && (s1_b_q[15:0] == Q15_NEG_ONE))
        |-> mem.wr_data == mem.rd_data + {{31{right_prod[31]}}, right_prod, 1'b0})
        else $error("product saturating accumulate wrong");

    a_sum_clamp: assert property (@(posedge clock) disable iff (sys_rst)
        is_sum_sat(s1_op_q) && (frac_sum[32] != frac_sum[31]) |-> frac_flag &&
        (mem.wr_data == (frac_sum[63] ? 64'hffff_ffff_8000_0000 : 64'h0000_0000_7fff_ffff)))
        else $error("accumulate clamp wrong");

    a_ovf_sticky: assert property (@(posedge clock) disable iff (sys_rst)
        !ctrl_wr |=> (ctrl_q[OVF_LSB+OVF_W-1:OVF_LSB] & $past(ctrl_q[OVF_LSB+OVF_W-1:OVF_LSB])) ==
        $past(ctrl_q[OVF_LSB+OVF_W-1:OVF_LSB]))
        else $error("overflow bit cleared by hardware");

    a_dsp_off: assert property (@(posedge clock) disable iff (sys_rst)
        instr_valid && dec_frac && !dsp_enable |-> ##1 !mem.wr_en ##1 dsp_exc_q && !gwr_q)
        else $error("disabled fractional op not refused");

    a_frac_no_exc: assert property (@(posedge clock) disable iff (sys_rst)
        instr_valid && dec_frac && dsp_enable |-> ##2 !res_exc_q && !dsp_exc_q)
        else $error("fractional op faulted");

    a_upper_decode: assert property (@(posedge clock) disable iff (sys_rst)
        instr_valid && grp_hit && (ext_code == EXT_READ_UPPER) && (instr_word[25:21] == 5'h00)
        |=> s1_op_q == OP_RDUP)
        else $error("read upper decode wrong");

    a_upper_reserved: assert property (@(posedge clock) disable iff (sys_rst)
        instr_valid && grp_hit && (ext_code == EXT_READ_UPPER) && (instr_word[25:21] != 5'h00)
        |-> ##2 res_exc_q && !gwr_q)
        else $error("read upper with nonzero field accepted");

    a_lower_word: assert property (@(posedge clock) disable iff (sys_rst)
        (s1_op_q == OP_UMAC) |->
        mem.wr_data[31:0] == 32'(mem.rd_data[31:0] + s1_a_q * s1_b_q))
        else $error("lower word of accumulate wrong");

    a_flag_race: assert property (@(posedge clock) disable iff (sys_rst)
        ctrl_wr && is_frac(s1_op_q) && prod_sat
        |=> ctrl_q[OVF_LSB + 32'($past(s1_sel_q))])
        else $error("software write hid a new overflow flag");
endmodule
`default_nettype wire

//--- test/pipeline_model.sv
// register file model of the issuing pipeline: supplies operands and takes write-backs
`default_nettype none
module pipeline_model
    import mac_pkg::*;
(
    input  wire logic              clock,
    input  wire logic [DATA_W-1:0] instr_word,
    input  wire logic              ld_en,
    input  wire logic [GREG_W-1:0] ld_idx,
    input  wire logic [DATA_W-1:0] ld_val,
    input  wire logic              general_register_wr,
    input  wire logic [GREG_W-1:0] general_register_idx,
    input  wire logic [DATA_W-1:0] general_register_data,
    output logic      [DATA_W-1:0] operand_a_value,
    output logic      [DATA_W-1:0] operand_b_value
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] regs_q [32];
    // operands follow the register fields of the word in the same cycle
    assign operand_a_value = regs_q[instr_word[FIELD2_MSB:FIELD2_LSB]];
    assign operand_b_value = regs_q[instr_word[FIELD1_MSB:FIELD1_LSB]];
    always @(posedge clock) begin
        if (ld_en) regs_q[ld_idx] <= ld_val;
        if (general_register_wr) regs_q[general_register_idx] <= general_register_data;
    end
endmodule
`default_nettype wire

//--- test/multiply_accumulate_datapath_tb_top.sv
// self-checking bench: random instruction streams against a behavioural accumulator model
`default_nettype none
module multiply_accumulate_datapath_tb_top
    import mac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, sys_rst, instr_valid, dsp_enable, reg_wr, reg_rd, ld_en, gwr, rexc, dexc, dsp_want;
    logic [31:0] instr_word, op_a, op_b, reg_wdata, rdata, gdata, ld_val, ctrl, rcur, r1;
    logic [7:0]  reg_addr;
    logic [4:0]  gidx, ld_idx;
    logic [39:0] cur, s1, s2;
    logic [63:0] acc [4];
    logic [31:0] grf [32];
    logic [7:0]  ops [8];
    int          n_mismatch, total_checks;

    mac_datapath u_mac_datapath (.clock(clock), .sys_rst(sys_rst), .instr_valid(instr_valid),
        .instr_word(instr_word), .operand_a_value(op_a), .operand_b_value(op_b), .dsp_enable(dsp_enable),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
        .general_register_wr(gwr), .general_register_idx(gidx), .general_register_data(gdata),
        .reserved_instr_exc(rexc), .dsp_disabled_exc(dexc));
    pipeline_model u_pipeline_model (.clock(clock), .instr_word(instr_word), .ld_en(ld_en), .ld_idx(ld_idx),
        .ld_val(ld_val), .general_register_wr(gwr), .general_register_idx(gidx),
        .general_register_data(gdata), .operand_a_value(op_a), .operand_b_value(op_b));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // results stand two edges after the instruction is taken, read data one edge after the read
    always @(posedge clock) begin
        if (!sys_rst) begin
            check({gwr, gidx, gdata, rexc, dexc}, s2);
            check({8'h00, rdata}, {8'h00, r1});
        end
        s2 <= s1;
        s1 <= cur;
        r1 <= rcur;
    end

    task automatic drive(input logic v, input logic [31:0] w, input logic [39:0] e, input logic ld,
                         input logic [4:0] li, input logic [31:0] lv, input logic wr, input logic rd,
                         input logic [7:0] a, input logic [31:0] wd, input logic [31:0] re);
        @(posedge clock);
        instr_valid <= v;
        instr_word  <= w;
        cur         <= e;
        dsp_enable  <= dsp_want;
        ld_en       <= ld;
        ld_idx      <= li;
        ld_val      <= lv;
        reg_wr      <= wr;
        reg_rd      <= rd;
        reg_addr    <= a;
        reg_wdata   <= wd;
        rcur        <= re;
    endtask

    task automatic idle();
        drive(0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
    endtask

    task automatic load(input logic [4:0] i, input logic [31:0] v);
        drive(0, 0, 0, 1, i, v, 0, 0, 0, 0, 0);
        grf[i] = v;
    endtask

    task automatic rd(input logic [7:0] a);
        drive(0, 0, 0, 0, 0, 0, 0, 1, a, 0, (a == CTRL_OFFSET) ? ctrl : 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        drive(0, 0, 0, 0, 0, 0, 1, 0, a, d, 0);
        if (a == CTRL_OFFSET) ctrl = d;
    endtask

    task automatic issue(input int k, input logic [1:0] sel, input logic [4:0] ra, input logic [4:0] rb);
        logic [39:0] e;
        logic [63:0] s;
        logic [31:0] p;
        logic [15:0] h1, h2;
        logic        f;
        e = '0;
        if (k == 0 && grf[rb] > grf[ra]) {ra, rb} = {rb, ra};
        if (k == 5) {ra, rb} = {5'd28 + 5'(sel), 5'd0};
        if (k == 7 && rb == 5'd0) rb = 5'd1;
        if (k == 0) acc[sel] = acc[sel] + {32'h0, grf[ra]} * {32'h0, grf[rb]};
        else if (k == 5) begin
            e = {1'b1, ra, acc[sel][63:32], 2'b00};
            grf[ra] = acc[sel][63:32];
        end else if (k > 5) e[1] = 1'b1;
        else if (!dsp_want) e[0] = 1'b1;
        else begin
            h1 = (k < 3) ? grf[ra][31:16] : grf[ra][15:0];
            h2 = (k < 3) ? grf[rb][31:16] : grf[rb][15:0];
            p = ($signed(h1) * $signed(h2)) <<< 1;
            f = (h1 == Q15_NEG_ONE) && (h2 == Q15_NEG_ONE);
            if (f) p = Q31_MAX;
            s = acc[sel] + {{32{p[31]}}, p};
            if ((k == 2 || k == 4) && s[32] != s[31]) begin
                f = 1'b1;
                s = s[63] ? {32'hffffffff, Q31_MIN} : {32'h0, Q31_MAX};
            end
            acc[sel] = s;
            if (f) ctrl[OVF_LSB + sel] = 1'b1;
        end
        // the destination index output follows bits 20..16 whatever the op
        e[38:34] = ra;
        drive(1, {MAJOR_GROUP, rb, ra, sel, ops[k], MINOR_GROUP}, e, 0, 0, 0, 0, 0, 0, 0, 0);
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        conclude();
    end

    initial begin
        logic [31:0] v;
        {sys_rst, instr_valid, dsp_enable, dsp_want, reg_wr, reg_rd, ld_en} = 7'b1011000;
        {instr_word, reg_wdata, ld_val, reg_addr, ld_idx} = '0;
        {cur, s1, s2, rcur, r1, ctrl, n_mismatch, total_checks} = '0;
        for (int i = 0; i < 4; i++) acc[i] = '0;
        ops = '{EXT_UNSIGNED_MAC, EXT_LEFT_PSAT, EXT_LEFT_SSAT, EXT_RIGHT_PSAT, EXT_RIGHT_SSAT,
                EXT_READ_UPPER, 8'h55, EXT_READ_UPPER};
        void'($urandom(32'hffa7602e));
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        rd(CTRL_OFFSET);
        rd(8'h04);
        wr(8'h04, 32'hffffffff);
        rd(CTRL_OFFSET);
        for (int i = 0; i < 32; i++) load(5'(i), $urandom);
        load(5'd1, 32'hffffffff);
        load(5'd2, 32'h80008000);
        load(5'd3, 32'h7fff7fff);
        for (int s = 0; s < 4; s++) begin
            issue(0, 2'(s), 5'd1, 5'd1);
            issue(1 + s, 2'(s), 5'd2, 5'd2);
            issue(2 + (s & 2), 2'(s), 5'd3, 5'd3);
            issue(5, 2'(s), 5'd0, 5'd0);
        end
        idle();
        idle();
        rd(CTRL_OFFSET);
        // a saturating op whose flag lands in the same cycle as a software clear
        issue(1, 2'd2, 5'd2, 5'd2);
        wr(CTRL_OFFSET, 32'h0);
        ctrl[OVF_LSB + 2] = 1'b1;
        rd(CTRL_OFFSET);
        wr(CTRL_OFFSET, 32'h0);
        rd(CTRL_OFFSET);
        for (int n = 0; n < 60; n++) begin
            for (int j = 0; j < 3; j++) begin
                v = $urandom;
                if ($urandom % 4 == 0) v[31:16] = Q15_NEG_ONE;
                if ($urandom % 4 == 0) v[15:0] = Q15_NEG_ONE;
                load(5'($urandom % 28), v);
            end
            for (int j = 0; j < 6; j++) begin
                dsp_want = ($urandom % 8) != 0;
                issue($urandom % 8, 2'($urandom), 5'($urandom % 28), 5'($urandom % 28));
            end
            dsp_want = 1'b1;
            idle();
            idle();
            rd(CTRL_OFFSET);
            if ($urandom % 3 == 0) wr(CTRL_OFFSET, $urandom);
            rd(8'($urandom % 255 + 1));
            rd(CTRL_OFFSET);
        end
        repeat (3) idle();
        conclude();
    end
endmodule
`default_nettype wire
